// [src/router_regs_pkg.sv]
`default_nettype none
package router_regs_pkg;

    // ------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------
    localparam int ADDR_W = 19;
    localparam int DATA_W = 32;

    // ------------------------------------------------------------
    // register and table byte offsets
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_OFFSET    = 19'h0_0000;
    localparam logic [ADDR_W-1:0] ERR_OFFSET     = 19'h0_0004;
    localparam logic [ADDR_W-1:0] COUNT_OFFSET   = 19'h0_0008;
    localparam logic [ADDR_W-1:0] STAMP_OFFSET   = 19'h0_000c;
    localparam logic [ADDR_W-1:0] KEY_BASE       = 19'h0_4000;
    localparam logic [ADDR_W-1:0] MASK_BASE      = 19'h0_8000;
    localparam logic [ADDR_W-1:0] ROUTE_BASE     = 19'h0_c000;
    localparam logic [ADDR_W-1:0] MC_SPAN        = 19'h0_1000;
    localparam logic [ADDR_W-1:0] P2P_BASE       = 19'h1_0000;
    localparam logic [ADDR_W-1:0] P2P_END        = 19'h5_0000;

    // ------------------------------------------------------------
    // table sizes
    // ------------------------------------------------------------
    localparam int MC_ENTRIES  = 1024;
    localparam int MC_AW       = 10;
    localparam int P2P_ENTRIES = 65536;
    localparam int P2P_AW      = 16;

    // ------------------------------------------------------------
    // control word fields
    // ------------------------------------------------------------
    localparam int CTRL_ERRANT_BIT   = 0;
    localparam int CTRL_SUPV_LSB     = 8;
    localparam int CTRL_SUPV_MSB     = 12;
    localparam int CTRL_REROUTE_LSB  = 16;
    localparam int CTRL_REROUTE_MSB  = 19;
    localparam int CTRL_DISCARD_LSB  = 20;
    localparam int CTRL_DISCARD_MSB  = 23;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // error flag fields
    // ------------------------------------------------------------
    localparam int NUM_TX_LINKS    = 6;
    localparam int NUM_CORES       = 20;
    localparam int OUT_PORTS       = 26;
    localparam int SUPV_PORT_BASE  = 6;
    localparam int ERR_TX_LSB      = 0;
    localparam int ERR_CORE_LSB    = 6;
    localparam int ERR_PARITY_BIT  = 26;
    localparam int ERR_FRAMING_BIT = 27;
    localparam int ERR_STAMP_BIT   = 28;
    localparam int ERR_STICKY_W    = 29;
    localparam int ERR_IRQ_EN_BIT  = 30;
    localparam int ERR_IRQ_ACT_BIT = 31;
    localparam logic [ERR_STICKY_W-1:0] ERR_RESET   = 29'h0000_0000;
    localparam logic [DATA_W-1:0]       COUNT_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // blocked-output wait sequencer
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        WAIT_IDLE  = 3'b001,
        WAIT_RETRY = 3'b010,
        WAIT_EMERG = 3'b100
    } wait_state_t;

endpackage : router_regs_pkg
`default_nettype wire

// [src/table_mem_if.sv]
`default_nettype none
interface table_mem_if #(
    parameter int AW = 10,
    parameter int DW = 32
) ();
    logic          wr_en;
    logic [AW-1:0] wr_addr;
    logic [DW-1:0] wr_data;
    logic [AW-1:0] rd_addr;
    logic [DW-1:0] rd_data;

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : table_mem_if
`default_nettype wire

// [src/route_table_mem.sv]
`default_nettype none
module route_table_mem #(
    parameter int DEPTH = 1024,
    parameter int AW    = 10,
    parameter int DW    = 32
) (
    input  wire logic  ref_clk_i, // core clock
    table_mem_if.mem   port       // write from bus, read for routing
);
    logic [DW-1:0] store [DEPTH];
    logic [DW-1:0] rd_data_reg;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    // no reset: contents undefined until loaded
    always_ff @(posedge ref_clk_i) begin
        if (port.wr_en) begin
            store[port.wr_addr] <= port.wr_data;
        end
        rd_data_reg <= store[port.rd_addr];
    end

    assign port.rd_data = rd_data_reg;
endmodule : route_table_mem
`default_nettype wire

// [src/router_config_status_regs.sv]
`default_nettype none
module router_config_status_regs
    import router_regs_pkg::*;
(
    input  wire  logic                                    ref_clk_i,            // core clock
    input  wire  logic                                    reset_i,              // sync reset, high
    input  wire  logic                                    reg_req_i,            // register access strobe
    input  wire  logic                                    reg_write_i,          // 1 write, 0 read
    input  wire  logic [router_regs_pkg::ADDR_W-1:0]      reg_addr_i,           // byte address
    input  wire  logic [router_regs_pkg::DATA_W-1:0]      reg_wdata_i,          // write data
    output logic                                          reg_ack_o,            // access done pulse
    output logic       [router_regs_pkg::DATA_W-1:0]      reg_rdata_o,          // read data
    input  wire  logic                                    packet_pass_i,        // one packet passed
    input  wire  logic [router_regs_pkg::NUM_TX_LINKS-1:0] tx_link_drop_i,      // tx link drop pulses
    input  wire  logic [router_regs_pkg::NUM_CORES-1:0]   core_link_drop_i,     // core link drop pulses
    input  wire  logic                                    parity_fault_i,       // rx parity fault
    input  wire  logic                                    framing_fault_i,      // rx length fault
    input  wire  logic                                    stamp_fault_i,        // rx time phase fault
    input  wire  logic                                    out_start_i,          // packet reaches output
    input  wire  logic                                    out_blocked_i,        // chosen output full
    input  wire  logic [router_regs_pkg::MC_AW-1:0]       mc_lookup_index_i,    // mc entry to read
    input  wire  logic [router_regs_pkg::P2P_AW-1:0]      p2p_lookup_dest_i,    // p2p destination
    output logic                                          errant_to_supervisor_o, // errant routing on
    output logic       [4:0]                              supervisor_core_id_o, // supervisor core
    output logic       [router_regs_pkg::OUT_PORTS-1:0]   supervisor_vector_o,  // errant output vector
    output logic       [3:0]                              reroute_delay_o,      // first wait limit
    output logic       [3:0]                              discard_delay_o,      // second wait limit
    output logic                                          try_emergency_o,      // start emergency pulse
    output logic                                          drop_packet_o,        // drop packet pulse
    output logic                                          router_irq_o,         // interrupt active
    output logic       [router_regs_pkg::DATA_W-1:0]      mc_key_o,             // key word
    output logic       [router_regs_pkg::DATA_W-1:0]      mc_mask_o,            // mask word
    output logic       [router_regs_pkg::DATA_W-1:0]      mc_route_o,           // route word
    output logic       [router_regs_pkg::DATA_W-1:0]      p2p_route_o           // p2p route word
);
    import router_regs_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [DATA_W-1:0]       ctrl_reg;
    logic [ERR_STICKY_W-1:0] flags_reg;
    logic [ERR_STICKY_W-1:0] flags_next;
    logic                    irq_en_reg;
    logic                    irq_en_next;
    logic [DATA_W-1:0]       count_reg;
    logic [DATA_W-1:0]       count_next;
    logic                    ack_reg;
    logic [DATA_W-1:0]       rdata_reg;
    logic [DATA_W-1:0]       rdata_next;
    logic [OUT_PORTS-1:0]    supv_vec_reg;
    logic                    irq_reg;
    wait_state_t             wait_reg;
    wait_state_t             wait_next;
    logic [3:0]              wait_cnt_reg;
    logic [3:0]              wait_cnt_next;
    logic                    try_emerg_reg;
    logic                    drop_reg;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    // window test for the three equal mc tables
    function automatic logic in_window(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] base);
        in_window = (addr >= base) && (addr < base + MC_SPAN);
    endfunction : in_window

    wire logic wr_stb    = reg_req_i && reg_write_i;
    wire logic hit_ctrl  = (reg_addr_i == CTRL_OFFSET);
    wire logic hit_err   = (reg_addr_i == ERR_OFFSET);
    wire logic hit_count = (reg_addr_i == COUNT_OFFSET);
    wire logic hit_key   = in_window(reg_addr_i, KEY_BASE);
    wire logic hit_mask  = in_window(reg_addr_i, MASK_BASE);
    wire logic hit_route = in_window(reg_addr_i, ROUTE_BASE);
    wire logic hit_p2p   = (reg_addr_i >= P2P_BASE) && (reg_addr_i < P2P_END);
    wire logic [ADDR_W-1:0] p2p_offset = reg_addr_i - P2P_BASE;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    // write-only from the bus; only its fields leave the block
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wr_stb && hit_ctrl) begin
            ctrl_reg <= reg_wdata_i;
        end
    end

    wire logic [4:0] supv_id = ctrl_reg[CTRL_SUPV_MSB:CTRL_SUPV_LSB];
    wire logic [3:0] reroute = ctrl_reg[CTRL_REROUTE_MSB:CTRL_REROUTE_LSB];
    wire logic [3:0] discard = ctrl_reg[CTRL_DISCARD_MSB:CTRL_DISCARD_LSB];

    // one-hot supervisor port; ids past the last core give no bit
    wire logic [OUT_PORTS-1:0] supv_vec_next =
        (supv_id < 5'(NUM_CORES)) ? (OUT_PORTS'(1) << (supv_id + 5'(SUPV_PORT_BASE))) : '0;

    // ------------------------------------------------------------
    // sticky error flags
    // ------------------------------------------------------------
    wire logic [ERR_STICKY_W-1:0] flag_events = {
        stamp_fault_i,
        framing_fault_i,
        parity_fault_i,
        core_link_drop_i,
        tx_link_drop_i
    };

    // a written zero clears; a same-cycle event wins
    assign flags_next = ((wr_stb && hit_err) ? (flags_reg & reg_wdata_i[ERR_STICKY_W-1:0]) : flags_reg)
                        | flag_events;
    assign irq_en_next = (wr_stb && hit_err) ? reg_wdata_i[ERR_IRQ_EN_BIT] : irq_en_reg;

    // bit 29 has no storage: writes vanish
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            flags_reg  <= ERR_RESET;
            irq_en_reg <= 1'b0;
        end else begin
            flags_reg  <= flags_next;
            irq_en_reg <= irq_en_next;
        end
    end

    wire logic irq_active = irq_en_reg && (|flags_reg);

    // ------------------------------------------------------------
    // packet counter
    // ------------------------------------------------------------
    // a load in a packet cycle keeps that packet
    wire logic [DATA_W-1:0] count_base = (wr_stb && hit_count) ? reg_wdata_i : count_reg;
    assign count_next = count_base + (packet_pass_i ? 32'h0000_0001 : 32'h0000_0000);

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            count_reg <= COUNT_RESET;
        end else begin
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // blocked output wait sequencer
    // ------------------------------------------------------------
    // a zero limit still costs one retry cycle, so a packet is never
    // dropped without at least one look at the output
    wire logic [4:0] cnt_plus = {1'b0, wait_cnt_reg} + 5'd1;
    wire logic       retry_done = cnt_plus >= {1'b0, reroute};
    wire logic       emerg_done = cnt_plus >= {1'b0, discard};

    always_comb begin
        wait_next     = wait_reg;
        wait_cnt_next = wait_cnt_reg;
        unique case (wait_reg)
            WAIT_IDLE: begin
                wait_cnt_next = 4'h0;
                if (out_start_i && out_blocked_i) begin
                    wait_next = WAIT_RETRY;
                end
            end
            WAIT_RETRY: begin
                if (!out_blocked_i) begin
                    wait_next = WAIT_IDLE;
                end else if (retry_done) begin
                    wait_next     = WAIT_EMERG;
                    wait_cnt_next = 4'h0;
                end else begin
                    wait_cnt_next = cnt_plus[3:0];
                end
            end
            WAIT_EMERG: begin
                if (!out_blocked_i || emerg_done) begin
                    wait_next = WAIT_IDLE;
                end else begin
                    wait_cnt_next = cnt_plus[3:0];
                end
            end
            default: begin
                wait_next     = WAIT_IDLE;
                wait_cnt_next = 4'h0;
            end
        endcase
    end

    wire logic go_emerg = (wait_reg == WAIT_RETRY) && out_blocked_i && retry_done;
    wire logic go_drop  = (wait_reg == WAIT_EMERG) && out_blocked_i && emerg_done;

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            wait_reg      <= WAIT_IDLE;
            wait_cnt_reg  <= 4'h0;
            try_emerg_reg <= 1'b0;
            drop_reg      <= 1'b0;
        end else begin
            wait_reg      <= wait_next;
            wait_cnt_reg  <= wait_cnt_next;
            try_emerg_reg <= go_emerg;
            drop_reg      <= go_drop;
        end
    end

    // ------------------------------------------------------------
    // read mux and answer
    // ------------------------------------------------------------
    // write-only locations read as zero
    always_comb begin
        rdata_next = '0;
        if (hit_err) begin
            rdata_next[ERR_STICKY_W-1:0] = flags_reg;
            rdata_next[ERR_IRQ_EN_BIT]   = irq_en_reg;
            rdata_next[ERR_IRQ_ACT_BIT]  = irq_active;
        end else if (hit_count) begin
            rdata_next = count_reg;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            ack_reg      <= 1'b0;
            rdata_reg    <= '0;
            supv_vec_reg <= '0;
            irq_reg      <= 1'b0;
        end else begin
            ack_reg      <= reg_req_i;
            rdata_reg    <= (reg_req_i && !reg_write_i) ? rdata_next : '0;
            supv_vec_reg <= supv_vec_next;
            irq_reg      <= irq_active;
        end
    end

    // ------------------------------------------------------------
    // routing tables
    // ------------------------------------------------------------
    table_mem_if #(.AW(MC_AW), .DW(DATA_W))  mc_if [3] ();
    table_mem_if #(.AW(P2P_AW), .DW(DATA_W)) p2p_if ();

    wire logic [2:0] mc_hit = {hit_route, hit_mask, hit_key};

    // key, mask and route share one index so entries stay paired
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_mc
            assign mc_if[g].wr_en   = wr_stb && mc_hit[g];
            assign mc_if[g].wr_addr = reg_addr_i[MC_AW+1:2];
            assign mc_if[g].wr_data = reg_wdata_i;
            assign mc_if[g].rd_addr = mc_lookup_index_i;
            route_table_mem #(.DEPTH(MC_ENTRIES), .AW(MC_AW), .DW(DATA_W)) u_mc (
                .ref_clk_i (ref_clk_i),
                .port      (mc_if[g])
            );
        end
    endgenerate

    assign p2p_if.wr_en   = wr_stb && hit_p2p;
    assign p2p_if.wr_addr = p2p_offset[P2P_AW+1:2];
    assign p2p_if.wr_data = reg_wdata_i;
    assign p2p_if.rd_addr = p2p_lookup_dest_i;

    route_table_mem #(.DEPTH(P2P_ENTRIES), .AW(P2P_AW), .DW(DATA_W)) u_p2p (
        .ref_clk_i (ref_clk_i),
        .port      (p2p_if)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_ack_o              = ack_reg;
    assign reg_rdata_o            = rdata_reg;
    assign errant_to_supervisor_o = ctrl_reg[CTRL_ERRANT_BIT];
    assign supervisor_core_id_o   = ctrl_reg[CTRL_SUPV_MSB:CTRL_SUPV_LSB];
    assign supervisor_vector_o    = supv_vec_reg;
    assign reroute_delay_o        = ctrl_reg[CTRL_REROUTE_MSB:CTRL_REROUTE_LSB];
    assign discard_delay_o        = ctrl_reg[CTRL_DISCARD_MSB:CTRL_DISCARD_LSB];
    assign try_emergency_o        = try_emerg_reg;
    assign drop_packet_o          = drop_reg;
    assign router_irq_o           = irq_reg;
    assign mc_key_o               = mc_if[0].rd_data;
    assign mc_mask_o              = mc_if[1].rd_data;
    assign mc_route_o             = mc_if[2].rd_data;
    assign p2p_route_o            = p2p_if.rd_data;

endmodule : router_config_status_regs
`default_nettype wire

// [testbench/router_regs_sva.sv]
`default_nettype none
module router_regs_sva
    import router_regs_pkg::*;
(
    input wire logic                                 ref_clk_i,            // clock
    input wire logic                                 reset_i,              // sync reset
    input wire logic                                 reg_req_i,            // strobe
    input wire logic                                 reg_write_i,          // write
    input wire logic [router_regs_pkg::ADDR_W-1:0]   reg_addr_i,           // address
    input wire logic [router_regs_pkg::DATA_W-1:0]   reg_wdata_i,          // write data
    input wire logic                                 reg_ack_o,            // answer
    input wire logic [router_regs_pkg::DATA_W-1:0]   reg_rdata_o,          // read data
    input wire logic                                 out_blocked_i,        // output full
    input wire logic [4:0]                           supervisor_core_id_o, // supervisor
    input wire logic [router_regs_pkg::OUT_PORTS-1:0] supervisor_vector_o, // errant vector
    input wire logic                                 try_emergency_o,      // reroute pulse
    input wire logic                                 drop_packet_o         // drop pulse
);
    timeunit 1ns;
    timeprecision 100ps;
    // ------
    // request held one cycle
    // ------
    logic              write_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [4:0]        id_q;
    // answer lands a cycle late: judge by the held request
    always_ff @(posedge ref_clk_i) begin
        write_q <= reg_write_i;
        addr_q  <= reg_addr_i;
        wdata_q <= reg_wdata_i;
        id_q    <= supervisor_core_id_o;
    end
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // ------
    // properties
    // ------
    ack_follows_a: assert property (reg_req_i |=> reg_ack_o) else $error("access unanswered");
    ack_only_a: assert property (!reg_req_i |=> !reg_ack_o) else $error("stray answer");
    idle_data_a: assert property (!reg_ack_o |-> reg_rdata_o == '0) else $error("data outside answer");
    write_data_a: assert property (reg_ack_o && write_q |-> reg_rdata_o == '0) else $error("data on write");
    unused_bit_a: assert property (reg_ack_o && addr_q == ERR_OFFSET
        |-> !reg_rdata_o[29]) else $error("unused bit set");
    irq_read_a: assert property (reg_ack_o && !write_q && addr_q == ERR_OFFSET
        |-> reg_rdata_o[31] == (reg_rdata_o[30] && |reg_rdata_o[28:0])) else $error("active bit wrong");
    ctrl_id_a: assert property (reg_req_i && reg_write_i && reg_addr_i == CTRL_OFFSET
        |=> supervisor_core_id_o == wdata_q[12:8]) else $error("supervisor id not loaded");
    sup_vector_a: assert property (!reset_i |=> supervisor_vector_o ==
        (id_q < 5'd20 ? OUT_PORTS'(1) << (id_q + 5'd6) : '0)) else $error("errant vector wrong");
    emerg_block_a: assert property (try_emergency_o |-> $past(out_blocked_i)) else $error("reroute unblocked");
    drop_block_a: assert property (drop_packet_o |-> $past(out_blocked_i)) else $error("drop unblocked");
    pulse_apart_a: assert property (!(try_emergency_o && drop_packet_o)) else $error("pulses overlap");
    cover property (try_emergency_o);
    cover property (drop_packet_o);
    cover property (reg_ack_o && reg_rdata_o[31]);
endmodule : router_regs_sva
bind router_config_status_regs router_regs_sva chk_u (
    .ref_clk_i, .reset_i, .reg_req_i, .reg_write_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o, .reg_rdata_o,
    .out_blocked_i, .supervisor_core_id_o, .supervisor_vector_o, .try_emergency_o, .drop_packet_o
);
`default_nettype wire

// [testbench/test_router_config_status_regs.sv]
`default_nettype none
module test_router_config_status_regs import router_regs_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    // ------
    // signals
    // ------
    logic                 ref_clk_i = 1'b0;
    logic                 reset_i, reg_req_i, reg_write_i, packet_pass_i, out_start_i, out_blocked_i, en;
    logic                 parity_fault_i, framing_fault_i, stamp_fault_i, reg_ack_o, router_irq_o;
    logic                 errant_to_supervisor_o, try_emergency_o, drop_packet_o;
    logic [ADDR_W-1:0]    reg_addr_i;
    logic [ADDR_W-1:0]    bases [4] = '{KEY_BASE, MASK_BASE, ROUTE_BASE, P2P_BASE};
    logic [DATA_W-1:0]    reg_wdata_i, reg_rdata_o, mc_key_o, mc_mask_o, mc_route_o, p2p_route_o, rd, d;
    logic [31:0]          seed = 32'h0000_52cb;
    logic [31:0]          w [4];
    logic [5:0]           tx_link_drop_i;
    logic [19:0]          core_link_drop_i;
    logic [28:0]          fl, ev;
    logic [MC_AW-1:0]     mc_lookup_index_i, mi;
    logic [P2P_AW-1:0]    p2p_lookup_dest_i, pi;
    logic [4:0]           supervisor_core_id_o;
    logic [OUT_PORTS-1:0] supervisor_vector_o;
    logic [3:0]           reroute_delay_o, discard_delay_o, r, dl;
    int                   bad_count = 0, compares = 0, cycles = 0, n, k;
    router_config_status_regs dut_u (
        .ref_clk_i, .reset_i, .reg_req_i, .reg_write_i, .reg_addr_i, .reg_wdata_i, .reg_ack_o, .reg_rdata_o,
        .packet_pass_i, .tx_link_drop_i, .core_link_drop_i, .parity_fault_i, .framing_fault_i, .stamp_fault_i,
        .out_start_i, .out_blocked_i, .mc_lookup_index_i, .p2p_lookup_dest_i, .errant_to_supervisor_o,
        .supervisor_core_id_o, .supervisor_vector_o, .reroute_delay_o, .discard_delay_o, .try_emergency_o,
        .drop_packet_o, .router_irq_o, .mc_key_o, .mc_mask_o, .mc_route_o, .p2p_route_o
    );
    // fault inputs driven from one event word
    assign {stamp_fault_i, framing_fault_i, parity_fault_i, core_link_drop_i, tx_link_drop_i} = ev;
    wire logic [13:0] ctrl_o = {errant_to_supervisor_o, supervisor_core_id_o, reroute_delay_o, discard_delay_o};
    // ------
    // clock, hang guard and helpers
    // ------
    always #2 ref_clk_i = ~ref_clk_i;
    // run needs well under 1000 cycles, so this trips only on a hang
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            test_done();
        end
    end
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    function logic [31:0] err_word(input logic [28:0] f, input logic e);
        return {e & (|f), e, 1'b0, f};
    endfunction : err_word
    function logic [25:0] sup_vec(input logic [4:0] id);
        return (id < 5'd20) ? 26'h1 << (id + 5'd6) : 26'h0;
    endfunction : sup_vec
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // inputs move 1 ns after the edge: no race
    task tick();
        @(posedge ref_clk_i);
        #1;
    endtask : tick
    // one strobe, answer taken, then one idle cycle
    task access(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
        {reg_req_i, reg_write_i, reg_addr_i, reg_wdata_i} = {1'b1, wr, a, wd};
        tick();
        rd = reg_rdata_o;
        chk(reg_ack_o, 1'b1);
        reg_req_i = 1'b0;
        tick();
    endtask : access
    task test_done();
        $display("compares %0d mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    // ------
    // main sequence
    // ------
    initial begin
        {reset_i, reg_req_i, reg_write_i, reg_addr_i, reg_wdata_i, packet_pass_i, out_start_i} = {1'b1, 55'h0};
        {mc_lookup_index_i, p2p_lookup_dest_i, fl, en, ev, out_blocked_i} = '0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        reset_i = 1'b0;
        chk(ctrl_o, 32'h0);
        // control fields; supervisor ids 19 and 20 first
        for (int i = 0; i < 10; i++) begin
            d = rnd();
            if (i < 2) d[12:8] = 5'd19 + 5'(i);
            access(1'b1, CTRL_OFFSET, d);
            chk(ctrl_o, {d[0], d[12:8], d[19:16], d[23:20]});
            chk(supervisor_vector_o, sup_vec(d[12:8]));
        end
        $display("control test done");
        // sticky flags: all sources, then random
        for (int i = 0; i < 8; i++) begin
            d = rnd();
            ev = (i == 0) ? 29'h1fff_ffff : d[28:0];
            fl = fl | ev;
            tick();
            ev = '0;
            access(1'b0, ERR_OFFSET, 32'h0);
            chk(rd, err_word(fl, en));
            d = (i == 1) ? 32'h4000_0000 : rnd();
            access(1'b1, ERR_OFFSET, d);
            {fl, en} = {fl & d[28:0], d[30]};
            access(1'b0, ERR_OFFSET, 32'h0);
            chk(rd, err_word(fl, en));
            chk(router_irq_o, en & (|fl));
        end
        $display("flag test done");
        // counter load then count, wrap case first
        for (int i = 0; i < 5; i++) begin
            d = (i == 0) ? 32'hffff_ffff : rnd();
            k = (i == 0) ? 2 : int'(d[2:0]);
            access(1'b1, COUNT_OFFSET, d);
            repeat (k) begin
                packet_pass_i = 1'b1;
                tick();
            end
            packet_pass_i = 1'b0;
            access(1'b0, COUNT_OFFSET, 32'h0);
            chk(rd, d + 32'(k));
        end
        $display("counter test done");
        // tables at top then random index; rest reads zero
        for (int i = 0; i < 6; i++) begin
            d = rnd();
            {mi, pi} = (i == 0) ? '1 : {d[9:0], d[31:16]};
            for (int j = 0; j < 4; j++) begin
                w[j] = rnd();
                access(1'b1, bases[j] + ((j == 3) ? {pi, 2'b00} : {mi, 2'b00}), w[j]);
            end
            {mc_lookup_index_i, p2p_lookup_dest_i} = {mi, pi};
            tick();
            chk(mc_key_o, w[0]);
            chk(mc_mask_o, w[1]);
            chk(mc_route_o, w[2]);
            chk(p2p_route_o, w[3]);
        end
        for (int j = 0; j < 4; j++) begin
            access(1'b0, (j == 3) ? 19'h0_0010 : (j == 2) ? STAMP_OFFSET : bases[j], 32'h0);
            chk(rd, 32'h0);
        end
        $display("table test done");
        // blocked output: zero and top waits first
        for (int i = 0; i < 5; i++) begin
            d = rnd();
            {r, dl} = (i == 0) ? 8'h0f : (i == 1) ? 8'hf0 : d[7:0];
            access(1'b1, CTRL_OFFSET, {8'h0, dl, r, 16'h0});
            {out_blocked_i, out_start_i} = 2'b11;
            tick();
            out_start_i = 1'b0;
            for (n = 0; try_emergency_o !== 1'b1 && n < 40; n++) tick();
            chk(n, (r == 0) ? 1 : r);
            for (n = 0; drop_packet_o !== 1'b1 && n < 40; n++) tick();
            chk(n, (dl == 0) ? 1 : dl);
            out_blocked_i = 1'b0;
            tick();
        end
        // output frees at once: no reroute or drop
        {out_blocked_i, out_start_i} = 2'b11;
        tick();
        {out_blocked_i, out_start_i} = 2'b00;
        n = 0;
        repeat (20) begin
            tick();
            if ({try_emergency_o, drop_packet_o} !== 2'b00) n++;
        end
        chk(n, 0);
        $display("wait test done");
        test_done();
    end
endmodule : test_router_config_status_regs
`default_nettype wire
